// ==== verilog/tmr_pkg.sv ====
`default_nettype none
package tmr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FORCE = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_CMPA = 8'h0C;
    localparam logic [7:0] OFF_CMPB = 8'h10;
    localparam logic [7:0] OFF_CAPT = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // control field positions
    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_COMA_LSB = 4;
    localparam int CTRL_COMB_LSB = 6;
    localparam int CTRL_DIRA = 8;
    localparam int CTRL_DIRB = 9;
    localparam int CTRL_PORTA = 10;
    localparam int CTRL_PORTB = 11;
    localparam int CTRL_W = 12;
    // flag bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_MATCHA = 1;
    localparam int FLG_MATCHB = 2;
    localparam int FLG_CAPT = 3;
    // waveform modes handled here
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CLR_A = 4'h4;
    localparam logic [3:0] WGM_CLR_CAPT = 4'hC;
    // compare output actions
    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // counter limits and reset values
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tmr_pkg
`default_nettype wire

// ==== verilog/tmr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - compare output mode zero leaves the waveform bit alone on match
// - new compare output mode acts from the next match after the write
// - force strobe applies set, clear or toggle at once in non-PWM modes
// - counting depends only on waveform mode, never on compare output mode
// - compare output mode selects set, clear or toggle on match
// - mode 0 only increments on enabled clocks, never cleared by match
// - mode 0 rolls from 0xFFFF to 0x0000 and keeps counting
// - overflow flag set in the cycle the count wraps from 0xFFFF to zero
// - hardware only sets overflow flag; servicing software clears it
// - software may write the counter at any time in mode 0
// - clear-on-match clears after count equals compare A or capture value
// - clear-on-match raises match A or capture flag at TOP
// - TOP register writes act directly, no double buffering
// - TOP written below count: count runs to 0xFFFF and wraps first
// - compare output mode 1 toggles output A on every match
// - output A reaches the pin only when its direction bit is 1
// - toggle frequency is clock over 2, prescale and compare A plus one
// - forced compare sets no flag and leaves the counter untouched
// - counter write blocks every match in the next timer clock cycle
// - nonzero compare output mode overrides port value, direction unchanged
// - system reset returns every waveform output bit to 0
module tmr_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // timer clock enable from the prescaler
    input wire logic tmr_en,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // waveform pins, enable low while driving
    output logic pin_a_out,
    output logic pin_a_oe_n,
    output logic pin_b_out,
    output logic pin_b_oe_n
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // registers are at most 16 bits wide, so only the two low lanes matter
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] d,
                                           input logic [1:0] s);
        logic [15:0] r;
        r = old;
        for (int i = 0; i < 2; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic apply_com(input logic cur, input logic [1:0] com);
        logic r;
        r = cur;
        case (com)
            tmr_pkg::COM_TOGGLE: r = ~cur;
            tmr_pkg::COM_CLEAR: r = 1'b0;
            tmr_pkg::COM_SET: r = 1'b1;
            default: r = cur;
        endcase
        return r;
    endfunction : apply_com

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [tmr_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [15:0] cnt_r, cnt_nxt, cmpa_r, cmpa_nxt, cmpb_r, cmpb_nxt, capt_r, capt_nxt;
    logic [3:0] flags_r, flags_nxt;
    logic wave_a_r, wave_a_nxt, wave_b_r, wave_b_nxt;
    logic block_r, block_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic [3:0] wgm;
    logic [1:0] com_a, com_b;
    logic non_pwm, wr_fire, cnt_wr, match_a, match_b, at_top, force_a, force_b;
    logic [15:0] ctrl_wr;
    logic [3:0] flag_set;

    assign wgm = ctrl_r[tmr_pkg::CTRL_WGM_LSB +: 4];
    assign com_a = ctrl_r[tmr_pkg::CTRL_COMA_LSB +: 2];
    assign com_b = ctrl_r[tmr_pkg::CTRL_COMB_LSB +: 2];
    assign non_pwm = (wgm == tmr_pkg::WGM_NORMAL) || (wgm == tmr_pkg::WGM_CLR_A)
                     || (wgm == tmr_pkg::WGM_CLR_CAPT);
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign cnt_wr = wr_fire && (aw_addr_r == tmr_pkg::OFF_COUNT);
    // compares run on live registers, so a new TOP or compare acts at once
    assign match_a = tmr_en && !block_r && (cnt_r == cmpa_r);
    assign match_b = tmr_en && !block_r && (cnt_r == cmpb_r);
    assign at_top = tmr_en && !block_r
                    && (((wgm == tmr_pkg::WGM_CLR_A) && (cnt_r == cmpa_r))
                    || ((wgm == tmr_pkg::WGM_CLR_CAPT) && (cnt_r == capt_r)));
    assign force_a = wr_fire && (aw_addr_r == tmr_pkg::OFF_FORCE) && wstrb_r[0]
                     && wdata_r[0] && non_pwm;
    assign force_b = wr_fire && (aw_addr_r == tmr_pkg::OFF_FORCE) && wstrb_r[0]
                     && wdata_r[1] && non_pwm;
    assign ctrl_wr = wmerge(16'(ctrl_r), wdata_r[15:0], wstrb_r[1:0]);
    // hardware set events this cycle, so a clear in the same cycle cannot lose one
    assign flag_set = {at_top && (wgm == tmr_pkg::WGM_CLR_CAPT), match_b, match_a,
                       tmr_en && (cnt_r == tmr_pkg::CNT_MAX)};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        cmpa_nxt = cmpa_r;
        cmpb_nxt = cmpb_r;
        capt_nxt = capt_r;
        flags_nxt = flags_r;
        wave_a_nxt = wave_a_r;
        wave_b_nxt = wave_b_r;
        block_nxt = block_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_addr_nxt = aw_addr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;

        // counting sequence, steered by waveform mode only
        if (tmr_en)
        begin
            block_nxt = 1'b0;
            if (at_top)
            begin
                cnt_nxt = tmr_pkg::CNT_BOTTOM;
            end
            else
            begin
                cnt_nxt = cnt_r + 16'h0001;
            end
            if (cnt_r == tmr_pkg::CNT_MAX)
            begin
                flags_nxt[tmr_pkg::FLG_OVF] = 1'b1;
            end
        end

        // match events; force touches only the waveform bits
        if (match_a)
        begin
            flags_nxt[tmr_pkg::FLG_MATCHA] = 1'b1;
        end
        if (match_b)
        begin
            flags_nxt[tmr_pkg::FLG_MATCHB] = 1'b1;
        end
        if (at_top && (wgm == tmr_pkg::WGM_CLR_CAPT))
        begin
            flags_nxt[tmr_pkg::FLG_CAPT] = 1'b1;
        end
        // pwm waveforms are outside this block, so only non-pwm modes act
        if ((match_a && non_pwm) || force_a)
        begin
            wave_a_nxt = apply_com(wave_a_r, com_a);
        end
        if ((match_b && non_pwm) || force_b)
        begin
            wave_b_nxt = apply_com(wave_b_r, com_b);
        end

        // axi write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = tmr_pkg::RESP_OKAY;
            if (aw_addr_r == tmr_pkg::OFF_CTRL)
            begin
                ctrl_nxt = ctrl_wr[tmr_pkg::CTRL_W-1:0];
            end
            else if (aw_addr_r == tmr_pkg::OFF_FORCE)
            begin
                bresp_nxt = tmr_pkg::RESP_OKAY;
            end
            else if (aw_addr_r == tmr_pkg::OFF_COUNT)
            begin
                cnt_nxt = wmerge(cnt_r, wdata_r[15:0], wstrb_r[1:0]);
                block_nxt = 1'b1;
            end
            else if (aw_addr_r == tmr_pkg::OFF_CMPA)
            begin
                cmpa_nxt = wmerge(cmpa_r, wdata_r[15:0], wstrb_r[1:0]);
            end
            else if (aw_addr_r == tmr_pkg::OFF_CMPB)
            begin
                cmpb_nxt = wmerge(cmpb_r, wdata_r[15:0], wstrb_r[1:0]);
            end
            else if (aw_addr_r == tmr_pkg::OFF_CAPT)
            begin
                capt_nxt = wmerge(capt_r, wdata_r[15:0], wstrb_r[1:0]);
            end
            else if (aw_addr_r == tmr_pkg::OFF_FLAGS)
            begin
                // write one to clear stands in for interrupt service; a set wins
                if (wstrb_r[0])
                begin
                    flags_nxt = flags_nxt & ~(wdata_r[3:0] & ~flag_set);
                end
            end
            else if (aw_addr_r != tmr_pkg::OFF_STATUS)
            begin
                bresp_nxt = tmr_pkg::RESP_SLVERR;
            end
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end

        // axi read
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = tmr_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (s_axi_araddr == tmr_pkg::OFF_CTRL)
            begin
                rdata_nxt = {20'h0_0000, ctrl_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_FORCE)
            begin
                rdata_nxt = 32'h0000_0000;
            end
            else if (s_axi_araddr == tmr_pkg::OFF_COUNT)
            begin
                rdata_nxt = {16'h0000, cnt_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_CMPA)
            begin
                rdata_nxt = {16'h0000, cmpa_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_CMPB)
            begin
                rdata_nxt = {16'h0000, cmpb_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_CAPT)
            begin
                rdata_nxt = {16'h0000, capt_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_FLAGS)
            begin
                rdata_nxt = {28'h000_0000, flags_r};
            end
            else if (s_axi_araddr == tmr_pkg::OFF_STATUS)
            begin
                rdata_nxt = {28'h000_0000, pin_b_out, pin_a_out, wave_b_r, wave_a_r};
            end
            else
            begin
                rresp_nxt = tmr_pkg::RESP_SLVERR;
            end
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_r <= tmr_pkg::CTRL_RST;
            cnt_r <= tmr_pkg::VAL_RST;
            cmpa_r <= tmr_pkg::VAL_RST;
            cmpb_r <= tmr_pkg::VAL_RST;
            capt_r <= tmr_pkg::VAL_RST;
            flags_r <= 4'h0;
            wave_a_r <= 1'b0;
            wave_b_r <= 1'b0;
            block_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= tmr_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= tmr_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            cmpa_r <= cmpa_nxt;
            cmpb_r <= cmpb_nxt;
            capt_r <= capt_nxt;
            flags_r <= flags_nxt;
            wave_a_r <= wave_a_nxt;
            wave_b_r <= wave_b_nxt;
            block_r <= block_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign pin_a_out = (com_a != tmr_pkg::COM_NONE) ? wave_a_r
                       : ctrl_r[tmr_pkg::CTRL_PORTA];
    assign pin_b_out = (com_b != tmr_pkg::COM_NONE) ? wave_b_r
                       : ctrl_r[tmr_pkg::CTRL_PORTB];
    assign pin_a_oe_n = !ctrl_r[tmr_pkg::CTRL_DIRA];
    assign pin_b_oe_n = !ctrl_r[tmr_pkg::CTRL_DIRB];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wrap_step;
        (wgm == tmr_pkg::WGM_NORMAL) && tmr_en && !cnt_wr && (cnt_r == tmr_pkg::CNT_MAX);
    endsequence
    property p_hold_idle;
        !tmr_en && !cnt_wr |=> (cnt_r == $past(cnt_r));
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("counter moved while idle");
    property p_wrap;
        s_wrap_step |=> (cnt_r == tmr_pkg::CNT_BOTTOM) && flags_r[tmr_pkg::FLG_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap or overflow flag");
    property p_inc;
        (wgm == tmr_pkg::WGM_NORMAL) && tmr_en && !cnt_wr && (cnt_r != tmr_pkg::CNT_MAX)
            |=> (cnt_r == $past(cnt_r) + 16'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("normal mode did not increment");
    property p_match_clear;
        (wgm == tmr_pkg::WGM_CLR_A) && match_a && !cnt_wr
            |=> (cnt_r == tmr_pkg::CNT_BOTTOM) && flags_r[tmr_pkg::FLG_MATCHA];
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("no clear at top");
    property p_com0;
        (com_a == tmr_pkg::COM_NONE) |=> (wave_a_r == $past(wave_a_r));
    endproperty
    a_com0: assert property (p_com0) else $error("output a changed with mode zero");
    property p_toggle;
        non_pwm && match_a && (com_a == tmr_pkg::COM_TOGGLE) |=> (wave_a_r != $past(wave_a_r));
    endproperty
    a_toggle: assert property (p_toggle) else $error("output a did not toggle");
    property p_block;
        cnt_wr |=> !match_a && !match_b;
    endproperty
    a_block: assert property (p_block) else $error("match after counter write");
    property p_force_noflag;
        force_a && !match_a && !tmr_en && !cnt_wr
            |=> (flags_r[tmr_pkg::FLG_MATCHA] == $past(flags_r[tmr_pkg::FLG_MATCHA]))
            && (cnt_r == $past(cnt_r));
    endproperty
    a_force_noflag: assert property (p_force_noflag) else $error("force touched flag");
    property p_pin_dir;
        pin_a_oe_n == !ctrl_r[tmr_pkg::CTRL_DIRA];
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin a drive mismatch");
endmodule : tmr_top
`default_nettype wire

// ==== bench/tmr_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port pin with pull-up
// ----------------------------------------
module tmr_pin_model (
    // from the timer
    input wire logic drv,
    input wire logic drv_oe_n,
    // pad level
    output logic pad
);
    // a released pad floats up, so a stale driven value never shows
    assign pad = drv_oe_n ? 1'b1 : drv;
endmodule : tmr_pin_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, rst, tmr_en, pa_prev;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, pad_a, pad_b;
    logic [1:0] fc [0:3];
    int fail_count, num_checks, tog;
    integer seed;

    tmr_top u_tmr_top (.sys_clk(sys_clk), .rst(rst), .tmr_en(tmr_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_a_out(pin_a_out),
        .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));
    tmr_pin_model u_pin_a (.drv(pin_a_out), .drv_oe_n(pin_a_oe_n), .pad(pad_a));
    tmr_pin_model u_pin_b (.drv(pin_b_out), .drv_oe_n(pin_b_oe_n), .pad(pad_b));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // counts pad edges, one cycle late, so the last toggle of a run is still seen
    always @(posedge sys_clk)
    begin
        if (pad_a !== pa_prev)
            tog = tog + 1;
        pa_prev = pad_a;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge sys_clk);
            if (!aw_ok && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (!w_ok && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok || s_axi_awready;
            w_ok = w_ok || s_axi_wready;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, exp, rdv);
    endtask : rdchk

    task automatic run(input int n);
        tmr_en <= 1'b1;
        repeat (n) @(posedge sys_clk);
        tmr_en <= 1'b0;
        @(posedge sys_clk);
    endtask : run

    // pins = {port b, port a, dir b, dir a}
    function automatic logic [31:0] mk(input logic [3:0] m, input logic [1:0] ca,
        input logic [1:0] cb, input logic [3:0] pins);
        return {20'h0_0000, pins, cb, ca, m};
    endfunction : mk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial
    begin
        #(40 * 6000);
        fail_count++;
        conclude();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        seed = 32'h9c2a_bb0e;
        {rst, tmr_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h1_0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
        {s_axi_wdata, s_axi_wstrb} = 36'h0_0000_0000;
        {tog, fail_count, num_checks, pa_prev} = 0;
        fc = '{tmr_pkg::COM_SET, tmr_pkg::COM_CLEAR, tmr_pkg::COM_TOGGLE, tmr_pkg::COM_TOGGLE};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("pin_a_out", 32'h0, pin_a_out);
        chk("pin_a_oe_n", 32'h1, pin_a_oe_n);
        rdchk("ctrl", tmr_pkg::OFF_CTRL, 32'h0);
        rdchk("bad_data", 8'h20, 32'h0);
        chk("bad_rresp", tmr_pkg::RESP_SLVERR, rsp);
        wr(8'h24, 32'h1);
        chk("bad_bresp", tmr_pkg::RESP_SLVERR, rsp);
        $display("test reset done");

        v = $random(seed) & 32'h7;
        wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_NORMAL, 2'h0, 2'h0, 4'h0));
        wr(tmr_pkg::OFF_COUNT, 32'h0000_fffe - v);
        run(v + 1);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h0000_ffff);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h0);
        run(1);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h0);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h1);
        run(3);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h3);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h7);
        wr(tmr_pkg::OFF_FLAGS, 32'hf);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h0);
        $display("test overflow done");

        v = ($random(seed) & 32'h7fff) + 32'h2;
        wr(tmr_pkg::OFF_CMPA, v);
        wr(tmr_pkg::OFF_COUNT, v);
        run(1);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h0);
        wr(tmr_pkg::OFF_COUNT, v - 1);
        run(2);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h2);
        rdchk("count", tmr_pkg::OFF_COUNT, v + 1);
        wr(tmr_pkg::OFF_FLAGS, 32'hf);
        $display("test block done");

        for (int i = 0; i < 4; i++)
        begin
            wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_NORMAL, fc[i], 2'h0, 4'h1));
            wr(tmr_pkg::OFF_FORCE, 32'h1);
            chk("pad_a", {31'h0, ~i[0]}, pad_a);
        end
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h0);
        rdchk("count", tmr_pkg::OFF_COUNT, v + 1);
        wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_NORMAL, 2'h0, 2'h0, 4'h5));
        chk("pad_a", 32'h1, pad_a);
        wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_NORMAL, tmr_pkg::COM_SET, 2'h0, 4'h0));
        wr(tmr_pkg::OFF_FORCE, 32'h1);
        chk("pin_a_oe_n", 32'h1, pin_a_oe_n);
        rdchk("status", tmr_pkg::OFF_STATUS, 32'h5);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdchk("status", tmr_pkg::OFF_STATUS, 32'h0);
        $display("test force done");

        v = $random(seed) & 32'h7;
        wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_CLR_A, tmr_pkg::COM_TOGGLE, 2'h0, 4'hb));
        wr(tmr_pkg::OFF_CMPA, v);
        wr(tmr_pkg::OFF_COUNT, 32'h0000_ffff);
        wr(tmr_pkg::OFF_FLAGS, 32'hf);
        tog = 0;
        run(1 + 4 * (v + 1));
        @(posedge sys_clk);
        chk("toggles", 32'h4, tog);
        chk("pad_b", 32'h1, pad_b);
        chk("pin_b_oe_n", 32'h0, pin_b_oe_n);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h0);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h7);
        rdchk("status", tmr_pkg::OFF_STATUS, 32'h8);
        $display("test toggle done");

        wr(tmr_pkg::OFF_CTRL, mk(tmr_pkg::WGM_CLR_CAPT, 2'h0, 2'h0, 4'h0));
        wr(tmr_pkg::OFF_CMPA, 32'h100);
        wr(tmr_pkg::OFF_CAPT, 32'h2);
        wr(tmr_pkg::OFF_COUNT, 32'h0000_fff0);
        wr(tmr_pkg::OFF_FLAGS, 32'hf);
        run(15);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h0000_ffff);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'h0);
        run(4);
        rdchk("count", tmr_pkg::OFF_COUNT, 32'h0);
        rdchk("flags", tmr_pkg::OFF_FLAGS, 32'hd);
        $display("test capture top done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
